// ==== nfc_regs.vh ====
// Functional notes
// - after ready, send 8Ah plus three target address cycles to program.
// - never partially program a copied page again before its block erase.
// - source and destination pages must share the plane address bit.
// - erase is 60h, two block address cycles, then D0h.
// - status mode holds until next command; reissue read to resume.
// - ID is 90h, address 00h, then two reads: maker then device code.
// - wait at least 10 us after power-up before any command.
// - hold write protect low during power transitions.
`ifndef NFC_REGS_VH
`define NFC_REGS_VH
// apb register offsets
`define NFC_OFF_CTRL     12'h000
`define NFC_OFF_ADDR     12'h004
`define NFC_OFF_STATUS   12'h008
`define NFC_OFF_RESULT   12'h00C
// ctrl fields: [3:0] operation, [8] write protect level
`define NFC_CTRL_OP_LSB  0
`define NFC_CTRL_OP_MSB  3
`define NFC_CTRL_WP_BIT  8
// operations
`define NFC_OP_COPYBACK  4'h1
`define NFC_OP_ERASE     4'h2
`define NFC_OP_STATUS    4'h3
`define NFC_OP_READID    4'h4
`define NFC_OP_RESET     4'h5
// address fields: [24:0] source page addr; destination page addr [24:0] written at the result offset
`define NFC_PLANE_BIT    14
// device commands
`define NFC_CMD_READ     8'h00
`define NFC_CMD_CB_PROG  8'h8A
`define NFC_CMD_ERASE1   8'h60
`define NFC_CMD_ERASE2   8'hD0
`define NFC_CMD_STATUS   8'h70
`define NFC_CMD_READID   8'h90
`define NFC_CMD_RESET    8'hFF
// status bits of the device
`define NFC_ST_FAIL      0
`define NFC_ST_READY     6
`define NFC_ST_NOPROT    7
`define NFC_ST_RESET_VAL 8'hC0
// timing
`define NFC_CLK_MHZ      200
`define NFC_PWRUP_US     10
`define NFC_PWRUP_CYC    (`NFC_PWRUP_US * `NFC_CLK_MHZ)
`define NFC_STROBE_CYC   4
`endif

// ==== nfc_bus_cycle.v ====
`timescale 1ns/1ps
`include "nfc_regs.vh"
// one byte cycle on the flash pins: command, address, data write or read
module nfc_bus_cycle #(
    parameter STROBE = `NFC_STROBE_CYC
) (
    // system
    input  wire       clk,
    input  wire       rst_b,
    // request
    input  wire       start,
    input  wire [1:0] kind,     // 0 cmd, 1 addr, 2 read
    input  wire [7:0] wdata,
    output wire       busy,
    output reg  [7:0] rdata_r,
    output reg        done_r,
    // pins (io_in already synchronised)
    input  wire [7:0] io_in,
    output reg  [7:0] io_out_r,
    output reg        io_oe_n_r,
    output reg        cle_r,
    output reg        ale_r,
    output reg        in_strobe_n_r,
    output reg        output_strobe_n_r
);
    localparam S_IDLE = 2'd0;
    localparam S_LOW  = 2'd1;
    localparam S_HIGH = 2'd2;
    reg [1:0] state_r;
    reg [7:0] cnt_r;
    reg [1:0] kind_r;
    assign busy = (state_r != S_IDLE);
    // strobe low phase then high phase; io read at end of low phase plus sync delay
    always @(posedge clk)
    begin
        done_r <= 1'b0;
        if (!rst_b)
        begin
            state_r           <= S_IDLE;
            cnt_r             <= 8'h00;
            kind_r            <= 2'd0;
            rdata_r           <= 8'h00;
            io_out_r          <= 8'h00;
            io_oe_n_r         <= 1'b1;
            cle_r             <= 1'b0;
            ale_r             <= 1'b0;
            in_strobe_n_r     <= 1'b1;
            output_strobe_n_r <= 1'b1;
        end
        else
        begin
            case (state_r)
                S_IDLE:
                begin
                    if (start)
                    begin
                        kind_r   <= kind;
                        io_out_r <= wdata;
                        io_oe_n_r <= (kind == 2'd2);
                        cle_r    <= (kind == 2'd0);
                        ale_r    <= (kind == 2'd1);
                        in_strobe_n_r     <= (kind == 2'd2);
                        output_strobe_n_r <= (kind != 2'd2);
                        cnt_r    <= 8'h00;
                        state_r  <= S_LOW;
                    end
                end
                S_LOW:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == STROBE[7:0] + 8'h02)   // extra for sync latency
                    begin
                        if (kind_r == 2'd2)
                            rdata_r <= io_in;
                        in_strobe_n_r     <= 1'b1;      // rising edge latches byte
                        output_strobe_n_r <= 1'b1;
                        cnt_r   <= 8'h00;
                        state_r <= S_HIGH;
                    end
                end
                S_HIGH:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == STROBE[7:0])
                    begin
                        io_oe_n_r <= 1'b1;
                        cle_r     <= 1'b0;
                        ale_r     <= 1'b0;
                        done_r    <= 1'b1;
                        state_r   <= S_IDLE;
                    end
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== nfc_host.v ====
`timescale 1ns/1ps
`include "nfc_regs.vh"
// flash controller: software starts operations over apb, sequencer drives pins
module nfc_host #(
    parameter PWRUP_CYC = `NFC_PWRUP_CYC
) (
    // system
    input  wire        CLK_SYS,
    input  wire        RST_B,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    output reg  [31:0] PRDATA,
    // flash pins
    input  wire [7:0]  IO_IN,
    output wire [7:0]  IO_OUT,
    output wire        IO_OE_N,
    output wire        CLE,
    output wire        ALE,
    output wire        CHIP_EN_N,
    output wire        IN_STROBE_N,
    output wire        OUTPUT_STROBE_N,
    output wire        WP_N,
    input  wire        RDY_BUSY_N
);
    localparam S_IDLE   = 3'd0;
    localparam S_ISSUE  = 3'd1;
    localparam S_WAIT   = 3'd2;
    localparam S_RBLOW  = 3'd3;
    localparam S_RBHIGH = 3'd4;
    // sequencer step kinds
    localparam K_CMD = 2'd0;
    localparam K_ADR = 2'd1;
    localparam K_RD  = 2'd2;
    localparam K_RB  = 2'd3;
    // registers
    reg  [3:0]  op_r;
    reg         wp_r;
    reg  [24:0] src_r;
    reg  [24:0] dst_r;
    reg  [7:0]  stat_r;
    reg  [7:0]  id0_r;
    reg  [7:0]  id1_r;
    reg         err_r;
    reg         run_r;
    reg  [2:0]  state_r;
    reg  [3:0]  step_r;
    reg  [15:0] pwr_cnt_r;
    reg  [7:0]  io_s1_r, io_s2_r;
    reg         rb_s1_r, rb_s2_r;
    // step decode
    reg  [1:0]  kind_w;
    reg  [7:0]  byte_w;
    reg         last_w;
    reg  [31:0] rd_mux_w;
    wire        cyc_busy;
    wire        cyc_done;
    wire [7:0]  cyc_rdata;
    wire        pwr_ok = (pwr_cnt_r == PWRUP_CYC[15:0]);
    wire        wr_en = PSEL & PENABLE & PWRITE;
    // copy-back across planes is refused before any pin moves
    wire        cb_bad = (PWDATA[3:0] == `NFC_OP_COPYBACK)
                         && (src_r[`NFC_PLANE_BIT] != dst_r[`NFC_PLANE_BIT]);
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    assign CHIP_EN_N = ~run_r;
    assign WP_N      = wp_r & pwr_ok;
    // one address byte of a page address
    function [7:0] adr_byte;
        input [24:0] a;
        input [1:0]  n;
        begin
            case (n)
                2'd0:    adr_byte = 8'h00;            // column start
                2'd1:    adr_byte = a[16:9];
                default: adr_byte = a[24:17];
            endcase
        end
    endfunction
    // pin input synchronisers
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            io_s1_r <= 8'h00;
            io_s2_r <= 8'h00;
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
        end
        else
        begin
            io_s1_r <= IO_IN;
            io_s2_r <= io_s1_r;
            rb_s1_r <= RDY_BUSY_N;
            rb_s2_r <= rb_s1_r;
        end
    end
    // power-up wait before first command
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
            pwr_cnt_r <= 16'h0000;
        else if (!pwr_ok)
            pwr_cnt_r <= pwr_cnt_r + 16'h0001;
    end
    // sequence tables per operation
    always @*
    begin
        kind_w = K_CMD;
        byte_w = 8'h00;
        last_w = 1'b0;
        case (op_r)
            `NFC_OP_COPYBACK:
            begin
                case (step_r)
                    4'd0: byte_w = `NFC_CMD_READ;
                    4'd1, 4'd2, 4'd3:
                    begin
                        kind_w = K_ADR;
                        byte_w = adr_byte(src_r, step_r[1:0] - 2'd1);
                    end
                    4'd4: kind_w = K_RB;
                    4'd5: byte_w = `NFC_CMD_CB_PROG;
                    4'd6, 4'd7, 4'd8:
                    begin
                        kind_w = K_ADR;
                        byte_w = adr_byte(dst_r, step_r[1:0] + 2'd2);
                    end
                    4'd9: kind_w = K_RB;
                    4'd10: byte_w = `NFC_CMD_STATUS;
                    default:
                    begin
                        kind_w = K_RD;
                        last_w = 1'b1;
                    end
                endcase
            end
            `NFC_OP_ERASE:
            begin
                case (step_r)
                    4'd0: byte_w = `NFC_CMD_ERASE1;
                    4'd1:
                    begin
                        kind_w = K_ADR;
                        byte_w = {src_r[16:14], 5'h00};
                    end
                    4'd2:
                    begin
                        kind_w = K_ADR;
                        byte_w = src_r[24:17];
                    end
                    4'd3: byte_w = `NFC_CMD_ERASE2;
                    4'd4: kind_w = K_RB;
                    4'd5: byte_w = `NFC_CMD_STATUS;
                    default:
                    begin
                        kind_w = K_RD;
                        last_w = 1'b1;
                    end
                endcase
            end
            `NFC_OP_STATUS:
            begin
                if (step_r == 4'd0)
                    byte_w = `NFC_CMD_STATUS;
                else
                begin
                    kind_w = K_RD;
                    last_w = 1'b1;
                end
            end
            `NFC_OP_READID:
            begin
                case (step_r)
                    4'd0: byte_w = `NFC_CMD_READID;
                    4'd1: kind_w = K_ADR;
                    4'd2: kind_w = K_RD;
                    default:
                    begin
                        kind_w = K_RD;
                        last_w = 1'b1;
                    end
                endcase
            end
            default:
            begin
                if (step_r == 4'd0)
                    byte_w = `NFC_CMD_RESET;
                else
                begin
                    kind_w = K_RB;
                    last_w = 1'b1;
                end
            end
        endcase
    end
    // operation sequencer
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            state_r <= S_IDLE;
            step_r  <= 4'h0;
            run_r   <= 1'b0;
            op_r    <= `NFC_OP_RESET;
            wp_r    <= 1'b0;
            src_r   <= 25'h000_0000;
            dst_r   <= 25'h000_0000;
            stat_r  <= 8'h00;
            id0_r   <= 8'h00;
            id1_r   <= 8'h00;
            err_r   <= 1'b0;
        end
        else
        begin
            if (wr_en && PADDR == `NFC_OFF_ADDR && !run_r)
                src_r <= PWDATA[24:0];
            if (wr_en && PADDR == `NFC_OFF_RESULT && !run_r)
                dst_r <= PWDATA[24:0];
            if (wr_en && PADDR == `NFC_OFF_CTRL)
                wp_r <= PWDATA[`NFC_CTRL_WP_BIT];
            case (state_r)
                S_IDLE:
                begin
                    // start refused until power-up wait ends or while running
                    if (wr_en && PADDR == `NFC_OFF_CTRL && pwr_ok
                        && PWDATA[3:0] >= `NFC_OP_COPYBACK && PWDATA[3:0] <= `NFC_OP_RESET)
                    begin
                        op_r    <= PWDATA[`NFC_CTRL_OP_MSB:`NFC_CTRL_OP_LSB];
                        // a refused copy-back leaves the pins idle and flags the error
                        err_r   <= cb_bad;
                        run_r   <= !cb_bad;
                        step_r  <= 4'h0;
                        if (!cb_bad)
                            state_r <= S_ISSUE;
                    end
                end
                S_ISSUE:
                begin
                    if (kind_w == K_RB)
                        state_r <= S_RBLOW;
                    else
                        state_r <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (cyc_done)
                    begin
                        if (kind_w == K_RD && op_r == `NFC_OP_READID && step_r == 4'd2)
                            id0_r <= cyc_rdata;
                        else if (kind_w == K_RD && op_r == `NFC_OP_READID)
                            id1_r <= cyc_rdata;
                        else if (kind_w == K_RD)
                            stat_r <= cyc_rdata;
                        if (last_w)
                        begin
                            run_r   <= 1'b0;
                            state_r <= S_IDLE;
                        end
                        else
                        begin
                            step_r  <= step_r + 4'h1;
                            state_r <= S_ISSUE;
                        end
                    end
                end
                S_RBLOW:
                begin
                    if (!rb_s2_r)
                        state_r <= S_RBHIGH;
                end
                S_RBHIGH:
                begin
                    // wait for ready before next command
                    if (rb_s2_r)
                    begin
                        if (last_w)
                        begin
                            run_r   <= 1'b0;
                            state_r <= S_IDLE;
                        end
                        else
                        begin
                            step_r  <= step_r + 4'h1;
                            state_r <= S_ISSUE;
                        end
                    end
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end
    // byte cycle engine
    nfc_bus_cycle u_cyc (
        .clk               (CLK_SYS),
        .rst_b             (RST_B),
        .start             (state_r == S_ISSUE && kind_w != K_RB && !cyc_busy),
        .kind              (kind_w),
        .wdata             (byte_w),
        .busy              (cyc_busy),
        .rdata_r           (cyc_rdata),
        .done_r            (cyc_done),
        .io_in             (io_s2_r),
        .io_out_r          (IO_OUT),
        .io_oe_n_r         (IO_OE_N),
        .cle_r             (CLE),
        .ale_r             (ALE),
        .in_strobe_n_r     (IN_STROBE_N),
        .output_strobe_n_r (OUTPUT_STROBE_N)
    );
    // apb read mux
    always @*
    begin
        case (PADDR)
            `NFC_OFF_CTRL:   rd_mux_w = {23'h00_0000, wp_r, 4'h0, op_r};
            `NFC_OFF_ADDR:   rd_mux_w = {7'h00, src_r};
            `NFC_OFF_STATUS: rd_mux_w = {16'h0000, 5'h00, pwr_ok, err_r, run_r, stat_r};
            `NFC_OFF_RESULT: rd_mux_w = {16'h0000, id1_r, id0_r};
            default:         rd_mux_w = 32'h0000_0000;
        endcase
    end
    // read data taken in the setup cycle so it stands through the access phase
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
            PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE)
            PRDATA <= rd_mux_w;
    end
endmodule

// ==== nfc_flash_model.sv ====
`timescale 1ns/1ps
// flash device; busy times counted on the bench clock
module nfc_flash_model #(
    parameter [7:0] MAKER_ID = 8'hA5, // arbitrary value
    parameter [7:0] DEV_ID   = 8'h3C, // arbitrary value
    parameter       T_BUSY   = 40,
    parameter       T_RST    = 12
) (
    // timebase and injected fault
    input  wire        clk,
    input  wire        fail_next,
    // flash pins
    input  wire [7:0]  io_out,
    output wire [7:0]  io_in,
    input  wire        cle,
    input  wire        ale,
    input  wire        chip_en_n,
    input  wire        in_strobe_n,
    input  wire        output_strobe_n,
    input  wire        wp_n,
    output wire        rdy_busy_n,
    // observation
    output reg  [15:0] src_page,
    output reg  [15:0] dst_page,
    output reg  [10:0] erase_blk,
    output reg  [7:0]  cb_cnt = 8'h00
);
    reg  [7:0] mode = 8'h00; // main_area_read_mode after power-up
    reg  [7:0] ab [0:2];
    reg  [1:0] acnt = 2'h0;
    reg  [7:0] bcnt = 8'h00;
    reg        rst_op = 1'b0;
    reg        fail = 1'b0;
    reg        idx = 1'b0;
    reg        we_q = 1'b1;
    reg        re_q = 1'b1;
    reg  [7:0] last = 8'h00;
    wire       busy = (bcnt != 8'h00);
    wire       lat = !chip_en_n && in_strobe_n && !we_q;
    wire       drv = !chip_en_n && !output_strobe_n;
    wire [7:0] stat = {wp_n, ~busy, 5'h00, fail};
    wire [7:0] val = (mode == 8'h70) ? stat : (idx ? DEV_ID : MAKER_ID);
    // released bus shows the inverse of the last byte so stale data never matches
    assign io_in = drv ? val : ~last;
    assign rdy_busy_n = busy ? 1'b0 : 1'b1; // open drain, pull-up
    // strobe edges are found by sampling, good enough for a registered host
    always @(posedge clk)
    begin
        we_q <= in_strobe_n;
        re_q <= output_strobe_n;
        if (drv)
            last <= val;
        if (busy)
            bcnt <= bcnt - 8'h01;
        if (mode == 8'h90 && !chip_en_n && output_strobe_n && !re_q)
            idx <= 1'b1;
        if (lat && cle && io_out == 8'hFF && !(rst_op && busy))
        begin
            bcnt <= T_RST;
            rst_op <= 1'b1;
            fail <= 1'b0;
            mode <= 8'hFF;
        end
        else if (lat && cle && io_out != 8'hFF && (!busy || io_out == 8'h70))
        begin
            mode <= io_out;
            acnt <= 2'h0;
            idx <= 1'b0;
            if (io_out == 8'hD0 && mode == 8'h60 && acnt == 2'h2)
            begin
                bcnt <= T_BUSY;
                rst_op <= 1'b0;
                fail <= fail_next;
                erase_blk <= {ab[1], ab[0][7:5]};
            end
        end
        if (lat && ale)
        begin
            ab[acnt] <= io_out;
            acnt <= acnt + 2'h1;
            if (acnt == 2'h2 && (mode == 8'h00 || mode == 8'h8A))
            begin
                bcnt <= T_BUSY;
                rst_op <= 1'b0;
            end
            if (acnt == 2'h2 && mode == 8'h00)
                src_page <= {io_out, ab[1]};
            if (acnt == 2'h2 && mode == 8'h8A)
            begin
                dst_page <= {io_out, ab[1]};
                cb_cnt <= cb_cnt + 8'h01;
                fail <= fail_next;
            end
        end
    end
endmodule

// ==== nfc_host_asserts.sv ====
`timescale 1ns/1ps
// pin-level checks on the controller side of the flash link
module nfc_host_asserts #(
    parameter PWRUP_CYC = 2000
) (
    // system
    input wire       CLK_SYS,
    input wire       RST_B,
    // flash pins
    input wire [7:0] IO_OUT,
    input wire       IO_OE_N,
    input wire       CLE,
    input wire       ALE,
    input wire       CHIP_EN_N,
    input wire       IN_STROBE_N,
    input wire       OUTPUT_STROBE_N,
    input wire       WP_N,
    input wire       RDY_BUSY_N
);
    reg        we_q_r;
    reg [7:0]  cmd_r;
    reg [1:0]  acnt_r;
    reg [31:0] pwr_r;
    wire       lat = IN_STROBE_N && !we_q_r && !CHIP_EN_N;
    // last latched command, addresses since it, cycles since reset
    always @(posedge CLK_SYS)
    begin
        we_q_r <= IN_STROBE_N;
        if (!RST_B)
        begin
            cmd_r <= 8'hFF;
            acnt_r <= 2'h0;
            pwr_r <= 32'h0000_0000;
        end
        else
        begin
            if (pwr_r < PWRUP_CYC)
                pwr_r <= pwr_r + 32'h0000_0001;
            if (lat && CLE)
            begin
                cmd_r <= IO_OUT;
                acnt_r <= 2'h0;
            end
            else if (lat && ALE)
                acnt_r <= acnt_r + 2'h1;
        end
    end
    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    a_quiet_pwrup: assert property (pwr_r < PWRUP_CYC |-> CHIP_EN_N && IN_STROBE_N)
        else $error("cycle before power-up wait");
    a_wp_pwrup: assert property (pwr_r < PWRUP_CYC |-> !WP_N)
        else $error("protect released early");
    a_strobe_width: assert property ($fell(IN_STROBE_N) |-> !IN_STROBE_N [*3])
        else $error("input strobe too short");
    a_latch_stable: assert property (lat |-> $stable(IO_OUT) && !IO_OE_N)
        else $error("bus moved at latch");
    a_read_cycle: assert property (!OUTPUT_STROBE_N |-> !CHIP_EN_N && IO_OE_N && IN_STROBE_N
        && !CLE && !ALE)
        else $error("bad read cycle");
    a_cb_ready: assert property (lat && CLE && IO_OUT == 8'h8A |->
        RDY_BUSY_N && $past(RDY_BUSY_N, 3))
        else $error("copy-back program while busy");
    a_erase_seq: assert property (lat && CLE && IO_OUT == 8'hD0 |->
        cmd_r == 8'h60 && acnt_r == 2'h2)
        else $error("erase confirm out of order");
    a_id_addr: assert property (lat && ALE && cmd_r == 8'h90 |-> IO_OUT == 8'h00)
        else $error("id address not zero");
    a_no_reprog: assert property (lat && CLE |-> IO_OUT != 8'h80 && IO_OUT != 8'h10)
        else $error("page program issued");
endmodule
bind nfc_host nfc_host_asserts #(.PWRUP_CYC(PWRUP_CYC)) u_chk (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N), .CLE(CLE),
    .ALE(ALE), .CHIP_EN_N(CHIP_EN_N), .IN_STROBE_N(IN_STROBE_N),
    .OUTPUT_STROBE_N(OUTPUT_STROBE_N), .WP_N(WP_N), .RDY_BUSY_N(RDY_BUSY_N)
);

// ==== tb_nfc_host.sv ====
`timescale 1ns/1ps
`include "nfc_regs.vh"
module tb_nfc_host;
    localparam PW = 20;
    reg         clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0000_0000;
    reg         fail_next = 1'b0;
    wire        pready, pslverr, oe_n, cle, ale, ce_n, we_n, re_n, wp_n, rb_n;
    wire [31:0] prdata;
    wire [7:0]  io_in, io_out, cb_cnt;
    wire [15:0] src_page, dst_page;
    wire [10:0] erase_blk;
    integer     num_errors = 0, tests_run = 0, i, n;
    reg  [31:0] exp_q[$], msk_q[$], rd_data, e, m, src, dst, ea;

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    nfc_host #(.PWRUP_CYC(PW)) uut (
        .CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
        .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_N(oe_n), .CLE(cle), .ALE(ale),
        .CHIP_EN_N(ce_n), .IN_STROBE_N(we_n), .OUTPUT_STROBE_N(re_n), .WP_N(wp_n),
        .RDY_BUSY_N(rb_n)
    );
    nfc_flash_model dev (
        .clk(clk), .fail_next(fail_next), .io_out(io_out), .io_in(io_in), .cle(cle),
        .ale(ale), .chip_en_n(ce_n), .in_strobe_n(we_n), .output_strobe_n(re_n), .wp_n(wp_n),
        .rdy_busy_n(rb_n), .src_page(src_page), .dst_page(dst_page), .erase_blk(erase_blk),
        .cb_cnt(cb_cnt)
    );

    task tally_and_finish;
    begin
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    task chk(input [31:0] g, input [31:0] x);
    begin
        tests_run = tests_run + 1;
        if (g !== x)
        begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, x);
        end
    end
    endtask

    task give_up;
    begin
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    endtask

    // completed reads are matched against the oldest note
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && msk_q.size() > 0)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk(prdata & m, e);
        end
    end

    // one apb transfer; for a read d is the expected value under mask k
    task apb(input w, input [11:0] a, input [31:0] d, input [31:0] k);
    begin
        if (!w)
        begin
            exp_q.push_back(d & k);
            msk_q.push_back(k);
        end
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0000_0000;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 40)
        begin
            n = n + 1;
            @(posedge clk);
        end
        rd_data = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40)
            give_up;
        @(posedge clk);
    end
    endtask

    // poll the running flag until the operation ends
    task wait_idle;
        integer t;
    begin
        t = 0;
        rd_data = 32'h0000_0100;
        while (rd_data[8] && t < 300)
        begin
            t = t + 1;
            apb(1'b0, `NFC_OFF_STATUS, 32'h0000_0000, 32'h0000_0000);
        end
        if (t >= 300)
            give_up;
    end
    endtask

    initial
    begin
        void'($urandom(75323));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(wp_n, 32'h0000_0000);
        apb(1'b1, `NFC_OFF_CTRL, 32'h0000_0105, 0);
        apb(1'b0, `NFC_OFF_STATUS, 32'h0000_0000, 32'h0000_0500);
        repeat (PW) @(posedge clk);
        apb(1'b0, `NFC_OFF_STATUS, 32'h0000_0400, 32'h0000_0500);
        apb(1'b1, `NFC_OFF_CTRL, 32'h0000_0105, 0);
        wait_idle;
        apb(1'b1, `NFC_OFF_CTRL, 32'h0000_0103, 0);
        wait_idle;
        apb(1'b0, `NFC_OFF_STATUS, 32'h0000_00C0, 32'h0000_03FF);
        apb(1'b1, `NFC_OFF_CTRL, 32'h0000_0104, 0);
        wait_idle;
        apb(1'b0, `NFC_OFF_RESULT, 32'h0000_3CA5, 32'h0000_FFFF);
        // pass, injected failure, then plane mismatch
        for (i = 0; i < 3; i = i + 1)
        begin
            src = $urandom & 32'h01FF_FE00;
            dst = ($urandom & 32'h01FF_BE00) | (src & 32'h0000_4000);
            if (i == 2)
                dst = dst ^ 32'h0000_4000;
            fail_next <= (i == 1);
            apb(1'b1, `NFC_OFF_ADDR, src, 0);
            apb(1'b1, `NFC_OFF_RESULT, dst, 0);
            apb(1'b1, `NFC_OFF_CTRL, 32'h0000_0101, 0);
            wait_idle;
            if (i < 2)
            begin
                apb(1'b0, `NFC_OFF_STATUS, 32'h0000_00C0 | i, 32'h0000_03FF);
                chk(src_page, {16'h0000, src[24:9]});
                chk(dst_page, {16'h0000, dst[24:9]});
            end
            else
                apb(1'b0, `NFC_OFF_STATUS, 32'h0000_0200, 32'h0000_0200);
            chk(cb_cnt, (i < 2) ? i + 1 : 2);
        end
        ea = $urandom & 32'h01FF_FE00;
        apb(1'b1, `NFC_OFF_ADDR, ea, 0);
        apb(1'b1, `NFC_OFF_CTRL, 32'h0000_0102, 0);
        wait_idle;
        chk(erase_blk, {21'h00_0000, ea[24:14]});
        apb(1'b0, `NFC_OFF_STATUS, 32'h0000_00C0, 32'h0000_01FF);
        apb(1'b1, `NFC_OFF_CTRL, 32'h0000_0003, 0);
        wait_idle;
        apb(1'b0, `NFC_OFF_STATUS, 32'h0000_0040, 32'h0000_00FF);
        tally_and_finish;
    end
endmodule
